/* File: include/acss_pkg.sv */
/*
 * acss_pkg: constants and carrier types for the analog clock source select block.
 * assumes: an 8-bit register port with read data one cycle after the read strobe.
 */
package acss_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_DBLK = 8;
    localparam int NUM_COL = 4;
    localparam logic [ADDR_W-1:0] ANALOG_CLOCK_SELECT_ADDR = 8'h61;
    localparam logic [ADDR_W-1:0] COLUMN_CLOCK_SELECT_ADDR = 8'h60;
    localparam logic [ADDR_W-1:0] PHASE_SWAP_ADDR = 8'h62;
    localparam logic [DATA_W-1:0] ANALOG_CLOCK_SELECT_RST = 8'h00;
    localparam logic [DATA_W-1:0] COLUMN_CLOCK_SELECT_RST = 8'h00;
    localparam logic [DATA_W-1:0] PHASE_SWAP_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    localparam int SRC_A_LSB = 0;
    localparam int SRC_B_LSB = 3;
    localparam int SAMPLE_HOLD_DISABLE_BIT = 6;
    localparam int COL_SEL_W = 2;
    localparam logic [1:0] COL_DIV_LAST = 2'h3;
    localparam logic [1:0] COL_DIV_HALF = 2'h2;
    localparam logic [1:0] COL_SEL_SRC_A = 2'h2;
    localparam logic [1:0] COL_SEL_SRC_B = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } acss_req_t;

    typedef struct packed {
        logic [NUM_COL-1:0] col_clk;
        logic [NUM_COL-1:0] first_clock_phase;
        logic [NUM_COL-1:0] second_clock_phase;
        logic [NUM_COL-1:0] bus_connect;
    } acss_col_t;
endpackage

/* File: verilog/acss_reg8.sv */
/*
 * acss_reg8: one 8-bit register with a synchronous reset value and write enable.
 * assumes: single clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module acss_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // write side
    input wire logic i_we,
    input wire logic [7:0] i_d,
    // stored value
    output logic [7:0] o_q
);
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (i_we) begin
            q_nxt = i_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule

/* File: verilog/acss_top.sv */
/*
 * acss_top: analog clock source select. picks two analog clocks from eight digital
 * block outputs, forms per-column clocks divided by four, and times output bus
 * connection of the switched-capacitor columns.
 * assumes: digital block outputs are asynchronous pins and are synchronised here;
 * register port is on i_clk.
 */
//
// Contract
// - bits 5:3 select the second analog clock from digital blocks 00..07.
// - bits 2:0 select the first analog clock with the same eight-way encoding.
// - with sample-and-hold on, a column without its swap bit connects the bus only in the last half of phase two.
// - a column's phase swap bit connects its output for all of phase two.
// - bit 6 set disables sample-and-hold so every column connects all of phase two.
// - the select register sits at 61h, all bits read-write, reset to zero.
// - each column picks a clock by a two-bit select and divides it by four.
`timescale 1ns/1ps
module acss_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // register port
    input wire logic [acss_pkg::ADDR_W-1:0] i_addr,
    input wire logic [acss_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [acss_pkg::DATA_W-1:0] o_rdata,
    // digital block clock outputs and system clock sources
    input wire logic [acss_pkg::NUM_DBLK-1:0] i_dblk_clk,
    input wire logic i_sys_clk_a,
    input wire logic i_sys_clk_b,
    // analog clocks and column timing
    output logic o_analog_clock_source_a,
    output logic o_analog_clock_source_b,
    output acss_pkg::acss_col_t o_col
);
    acss_pkg::acss_req_t req;
    logic [7:0] clk_sel_q;
    logic [7:0] col_sel_q;
    logic [7:0] swap_q;
    logic we_sel;
    logic we_col;
    logic we_swap;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    function automatic logic hit(input logic [acss_pkg::ADDR_W-1:0] a,
                                 input logic [acss_pkg::ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    always_comb begin
        we_sel = 1'b0;
        we_col = 1'b0;
        we_swap = 1'b0;
        if (req.wr && hit(req.addr, acss_pkg::ANALOG_CLOCK_SELECT_ADDR)) begin
            we_sel = 1'b1;
        end else if (req.wr && hit(req.addr, acss_pkg::COLUMN_CLOCK_SELECT_ADDR)) begin
            we_col = 1'b1;
        end else if (req.wr && hit(req.addr, acss_pkg::PHASE_SWAP_ADDR)) begin
            we_swap = 1'b1;
        end
    end

    // bit 7 is kept here for readback only; nothing below looks at it
    acss_reg8 #(.RST_VAL(acss_pkg::ANALOG_CLOCK_SELECT_RST)) u_sel (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(we_sel),
        .i_d(req.wdata),
        .o_q(clk_sel_q)
    );
    acss_reg8 #(.RST_VAL(acss_pkg::COLUMN_CLOCK_SELECT_RST)) u_col (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(we_col),
        .i_d(req.wdata),
        .o_q(col_sel_q)
    );
    acss_reg8 #(.RST_VAL(acss_pkg::PHASE_SWAP_RST)) u_swap (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(we_swap),
        .i_d(req.wdata),
        .o_q(swap_q)
    );

    // read path
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = acss_pkg::UNMAPPED_READ;
        if (!req.rd) begin
            rdata_nxt = acss_pkg::UNMAPPED_READ;
        end else if (hit(req.addr, acss_pkg::ANALOG_CLOCK_SELECT_ADDR)) begin
            rdata_nxt = clk_sel_q;
        end else if (hit(req.addr, acss_pkg::COLUMN_CLOCK_SELECT_ADDR)) begin
            rdata_nxt = col_sel_q;
        end else if (hit(req.addr, acss_pkg::PHASE_SWAP_ADDR)) begin
            rdata_nxt = swap_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_r <= acss_pkg::UNMAPPED_READ;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // pin synchronisers: first stage feeds only the second
    logic [acss_pkg::NUM_DBLK+1:0] sync1_r;
    logic [acss_pkg::NUM_DBLK+1:0] sync2_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {i_sys_clk_b, i_sys_clk_a, i_dblk_clk};
            sync2_r <= sync1_r;
        end
    end

    logic [acss_pkg::NUM_DBLK-1:0] dblk_s;
    logic sys_a_s;
    logic sys_b_s;
    assign dblk_s = sync2_r[acss_pkg::NUM_DBLK-1:0];
    assign sys_a_s = sync2_r[acss_pkg::NUM_DBLK];
    assign sys_b_s = sync2_r[acss_pkg::NUM_DBLK+1];

    logic [2:0] src_a_sel;
    logic [2:0] src_b_sel;
    logic sample_hold_disable;
    assign src_a_sel = clk_sel_q[acss_pkg::SRC_A_LSB +: 3];
    assign src_b_sel = clk_sel_q[acss_pkg::SRC_B_LSB +: 3];
    assign sample_hold_disable = clk_sel_q[acss_pkg::SAMPLE_HOLD_DISABLE_BIT];

    logic aclk_a_r;
    logic aclk_b_r;
    logic aclk_a_nxt;
    logic aclk_b_nxt;

    always_comb begin
        aclk_a_nxt = dblk_s[src_a_sel];
        aclk_b_nxt = dblk_s[src_b_sel];
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            aclk_a_r <= 1'b0;
            aclk_b_r <= 1'b0;
        end else begin
            aclk_a_r <= aclk_a_nxt;
            aclk_b_r <= aclk_b_nxt;
        end
    end

    assign o_analog_clock_source_a = aclk_a_r;
    assign o_analog_clock_source_b = aclk_b_r;

    // per-column clock: count rising edges of the chosen source; the count's
    // top bit is the divide-by-four clock, phase one is its first half
    logic [acss_pkg::NUM_COL-1:0] src_lvl;
    logic [acss_pkg::NUM_COL-1:0] src_prev_r;
    logic [acss_pkg::NUM_COL-1:0] src_prev_nxt;
    logic [1:0] div_r [acss_pkg::NUM_COL];
    logic [1:0] div_nxt [acss_pkg::NUM_COL];
    acss_pkg::acss_col_t col_r;
    acss_pkg::acss_col_t col_nxt;

    genvar g;
    generate
        for (g = 0; g < acss_pkg::NUM_COL; g++) begin : g_col
            logic [1:0] csel;
            assign csel = col_sel_q[g*acss_pkg::COL_SEL_W +: acss_pkg::COL_SEL_W];

            always_comb begin
                if (csel == acss_pkg::COL_SEL_SRC_A) begin
                    src_lvl[g] = aclk_a_r;
                end else if (csel == acss_pkg::COL_SEL_SRC_B) begin
                    src_lvl[g] = aclk_b_r;
                end else if (csel[0]) begin
                    src_lvl[g] = sys_b_s;
                end else begin
                    src_lvl[g] = sys_a_s;
                end
                src_prev_nxt[g] = src_lvl[g];
                div_nxt[g] = div_r[g];
                if (src_lvl[g] && !src_prev_r[g]) begin
                    div_nxt[g] = div_r[g] + 2'h1;
                end
                col_nxt.col_clk[g] = div_nxt[g][1];
                col_nxt.first_clock_phase[g] = !div_nxt[g][1];
                col_nxt.second_clock_phase[g] = div_nxt[g][1];
                // holding the bus in phase one and early phase two hides settling
                if (sample_hold_disable || swap_q[g]) begin
                    col_nxt.bus_connect[g] = div_nxt[g][1];
                end else begin
                    col_nxt.bus_connect[g] = (div_nxt[g] == acss_pkg::COL_DIV_LAST);
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    div_r[g] <= 2'h0;
                    src_prev_r[g] <= 1'b0;
                end else begin
                    div_r[g] <= div_nxt[g];
                    src_prev_r[g] <= src_prev_nxt[g];
                end
            end

            // col_r was built from last cycle's control bits, so those are what count
            a_bus_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                (!$past(sample_hold_disable) && !$past(swap_q[g]) && col_r.bus_connect[g])
                    |-> (div_r[g] == acss_pkg::COL_DIV_LAST))
                else $error("bus connected outside last half of phase two");
            a_bus_full: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                (($past(sample_hold_disable) || $past(swap_q[g])) && div_r[g] == acss_pkg::COL_DIV_HALF)
                    |-> col_r.bus_connect[g])
                else $error("bus not connected in early phase two when forced");
            a_div_phase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
                col_r.second_clock_phase[g] == div_r[g][1])
                else $error("column phase not tied to divider");
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            col_r <= '0;
        end else begin
            col_r <= col_nxt;
        end
    end

    assign o_col = col_r;

    a_src_b_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ##1 (aclk_b_r == $past(dblk_s[src_b_sel])))
        else $error("second analog clock not from selected block");
    a_src_a_sel: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ##1 (aclk_a_r == $past(dblk_s[src_a_sel])))
        else $error("first analog clock not from selected block");
    a_sample_hold_disable_all: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        ($past(sample_hold_disable) && col_r.first_clock_phase == '0)
            |-> (col_r.bus_connect == col_r.col_clk))
        else $error("disable bit did not connect all columns");
    a_reg_rdback: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (i_rd && i_addr == acss_pkg::ANALOG_CLOCK_SELECT_ADDR)
            |=> (o_rdata == $past(clk_sel_q)))
        else $error("select register readback wrong");
    a_rsvd_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        we_sel |=> (clk_sel_q == $past(i_wdata)))
        else $error("select register write not stored in full");
endmodule

/* File: verif/acss_far_model.sv */
/*
 * acss_far_model: digital block clock outputs and the two system clock sources.
 * assumes: driven from the bench clock; each source toggles at its own rate.
 */
`timescale 1ns/1ps
module acss_far_model (
    // clock
    input wire logic i_clk,
    // clock sources seen by the block
    output logic [7:0] o_dblk_clk,
    output logic o_sys_clk_a,
    output logic o_sys_clk_b
);
    logic [9:0] lvl_r = '0;
    int cnt [0:9];

    initial begin
        for (int i = 0; i < 10; i++) begin
            cnt[i] = 0;
        end
    end

    // half periods of at least two cycles so the synchronisers never miss a level
    always @(posedge i_clk) begin
        for (int i = 0; i < 10; i++) begin
            if (cnt[i] >= i + 1) begin
                cnt[i] <= 0;
                lvl_r[i] <= ~lvl_r[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    assign o_dblk_clk = lvl_r[7:0];
    assign o_sys_clk_a = lvl_r[8];
    assign o_sys_clk_b = lvl_r[9];
endmodule

/* File: verif/acss_top_test.sv */
/*
 * acss_top_test: self-checking bench for the analog clock source select block.
 * assumes: acss_pkg compiled first; far side clocks come from acss_far_model.
 */
`timescale 1ns/1ps
module acss_top_test;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    wire logic [7:0] o_rdata;
    wire logic [7:0] dblk;
    wire logic sys_a;
    wire logic sys_b;
    wire logic clk_a;
    wire logic clk_b;
    acss_pkg::acss_col_t col;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h0000004C;
    logic [7:0] hist [0:2];

    always #5 i_clk = ~i_clk;

    acss_far_model far (.i_clk(i_clk), .o_dblk_clk(dblk), .o_sys_clk_a(sys_a),
        .o_sys_clk_b(sys_b));

    acss_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_dblk_clk(dblk), .i_sys_clk_a(sys_a), .i_sys_clk_b(sys_b),
        .o_analog_clock_source_a(clk_a), .o_analog_clock_source_b(clk_b), .o_col(col));

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // source levels three edges back: two synchroniser flops plus the output register
    always @(posedge i_clk) begin
        hist[0] <= dblk;
        for (int i = 1; i < 3; i++) begin
            hist[i] <= hist[i-1];
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask

    task automatic selchk(input logic [2:0] a, input logic [2:0] b);
        int erra;
        int errb;
        logic [7:0] v;
        erra = 0;
        errb = 0;
        v = rnd();
        wr(8'h61, {v[7], 1'b0, b, a});
        repeat (10) @(posedge i_clk);
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (clk_a !== hist[2][a]) erra++;
            if (clk_b !== hist[2][b]) errb++;
        end
        chk({7'h00, erra != 0}, 8'h00);
        chk({7'h00, errb != 0}, 8'h00);
    endtask

    // col0 has its swap bit set; the rest follow sample-and-hold unless full is set
    task automatic colchk(input logic full);
        int err;
        int gaps;
        int ra;
        int rc;
        int cons;
        logic pa;
        logic pc;
        logic [3:0] ps;
        err = 0;
        gaps = 0;
        ra = 0;
        rc = 0;
        cons = 0;
        ps = 4'hF;
        pa = clk_a;
        pc = col.col_clk[1];
        repeat (160) begin
            @(posedge i_clk);
            #1;
            for (int i = 0; i < 4; i++) begin
                if (col.col_clk[i] !== col.second_clock_phase[i]) err++;
                if (col.first_clock_phase[i] !== !col.second_clock_phase[i]) err++;
                if (full || i == 0) begin
                    if (col.bus_connect[i] !== col.second_clock_phase[i]) err++;
                end else begin
                    if (col.bus_connect[i] && !col.second_clock_phase[i]) err++;
                    if (col.bus_connect[i] && col.first_clock_phase[i]) err++;
                    // the first cycle of phase two belongs to its first half
                    if (col.bus_connect[i] && !ps[i]) err++;
                    if (col.second_clock_phase[i] && !col.bus_connect[i]) gaps++;
                    if (col.bus_connect[i]) cons++;
                end
            end
            ps = col.second_clock_phase;
            if (clk_a && !pa) ra++;
            if (col.col_clk[1] && !pc) rc++;
            pa = clk_a;
            pc = col.col_clk[1];
        end
        chk({7'h00, err != 0}, 8'h00);
        if (!full) chk({7'h00, gaps > 0}, 8'h01);
        if (!full) chk({7'h00, cons > 0}, 8'h01);
        chk({7'h00, rc * 4 >= ra - 4 && rc * 4 <= ra + 4 && rc > 0}, 8'h01);
        $display("column test done, full phase two %0d", full);
    endtask

    initial begin
        logic [7:0] v;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(8'h61, 8'h00);
        rd(8'h60, 8'h00);
        rd(8'h62, 8'h00);
        rd(8'h10, 8'h00);
        $display("reset test done");
        repeat (8) begin
            v = rnd();
            wr(8'h61, v);
            rd(8'h61, v);
        end
        $display("readback test done");
        for (int s = 0; s < 8; s++) begin
            selchk(3'(s), 3'(7 - s));
        end
        $display("selection test done");
        wr(8'h60, 8'hEA);
        wr(8'h62, 8'h01);
        wr(8'h61, 8'h08);
        colchk(1'b0);
        // columns 2 and 3 move to the two system clocks so every select code is used
        wr(8'h60, 8'h4A);
        wr(8'h61, 8'h48);
        colchk(1'b1);
        summarize();
    end
endmodule
